//--- rtl/core_sfr_defs.vh
`ifndef CORE_SFR_DEFS_VH
`define CORE_SFR_DEFS_VH

// ---------------------------------------------------------------
// Register offsets (byte addresses in the core file space)
// ---------------------------------------------------------------
`define OFF_WINDOW_ZERO     7'h00
`define OFF_WINDOW_ONE      7'h01
`define OFF_PC_LOW_BYTE     7'h02
`define OFF_STATUS_FLAGS    7'h03
`define OFF_PTR_ZERO_LOW    7'h04
`define OFF_PTR_ZERO_HIGH   7'h05
`define OFF_PTR_ONE_LOW     7'h06
`define OFF_PTR_ONE_HIGH    7'h07
`define OFF_BANK_SELECT     7'h08
`define OFF_WORKING_ACC     7'h09
`define OFF_PC_UPPER_LATCH  7'h0a

// ---------------------------------------------------------------
// Status field positions
// ---------------------------------------------------------------
`define BIT_TIMEOUT         4
`define BIT_POWERDOWN       3
`define BIT_ZERO            2
`define BIT_DIGIT_CARRY     1
`define BIT_CARRY           0

// ---------------------------------------------------------------
// Reset values and field widths
// ---------------------------------------------------------------
`define RST_BYTE            8'h00
`define RST_POINTER         16'h0000
`define RST_BANK            6'h00
`define RST_LATCH           7'h00
`define BANK_WIDTH          6
`define LATCH_WIDTH         7
`define PROG_SPACE_BIT      15

// ---------------------------------------------------------------
// Flag operation codes from the execution core
// ---------------------------------------------------------------
`define FOP_NONE            3'h0
`define FOP_ADD             3'h1
`define FOP_SUB             3'h2
`define FOP_LOGIC           3'h3
`define FOP_ROT_LEFT        3'h4
`define FOP_ROT_RIGHT       3'h5

`endif

//--- rtl/flag_alu.v
`timescale 1ns/10ps
`default_nettype none

// Arithmetic flag generator: add, subtract, logic, rotate through carry
module flag_alu (
    // Operands and operation
    input wire [2:0] op,
    input wire [7:0] opnd_a,
    input wire [7:0] opnd_b,
    input wire carry_in,
    // Result and flags
    output reg [7:0] result,
    output reg zero_out,
    output reg digit_carry_out,
    output reg carry_out,
    output reg carry_valid
);
`include "core_sfr_defs.vh"

    reg [8:0] full_sum;
    reg [4:0] nib_sum;
    reg [7:0] b_eff;

    // Subtract adds the two's complement, so carry reads as not-borrow
    always @* begin
        b_eff = (op == `FOP_SUB) ? ~opnd_b : opnd_b;
        full_sum = {1'b0, opnd_a} + {1'b0, b_eff}
            + {8'h00, (op == `FOP_SUB)};
        nib_sum = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]}
            + {4'h0, (op == `FOP_SUB)};
        result = full_sum[7:0];
        digit_carry_out = nib_sum[4];
        carry_out = full_sum[8];
        carry_valid = 1'b1;
        case (op)
            `FOP_ADD, `FOP_SUB: begin
                carry_valid = 1'b1;
            end
            `FOP_LOGIC: begin
                result = opnd_a;
                carry_valid = 1'b0;
            end
            `FOP_ROT_LEFT: begin
                result = {opnd_a[6:0], carry_in};
                carry_out = opnd_a[7];
            end
            `FOP_ROT_RIGHT: begin
                result = {carry_in, opnd_a[7:1]};
                carry_out = opnd_a[0];
            end
            default: begin
                carry_valid = 1'b0;
            end
        endcase
        zero_out = (result == 8'h00);
    end

endmodule // flag_alu

`default_nettype wire

//--- rtl/addr_former.v
`timescale 1ns/10ps
`default_nettype none

// Forms direct and indirect data addresses from bank and pointers
module addr_former (
    // Direct addressing
    input wire [5:0] bank,
    input wire [6:0] file_offset,
    // Indirect addressing
    input wire [15:0] pointer,
    // Outputs
    output wire [12:0] direct_addr,
    output wire [14:0] indirect_addr,
    output wire indirect_is_prog
);
`include "core_sfr_defs.vh"

    // Bank bits are the top six of the direct address
    assign direct_addr = {bank, file_offset};
    // Top pointer bit steers into program memory, low 15 bits address it
    assign indirect_is_prog = pointer[`PROG_SPACE_BIT];
    assign indirect_addr = pointer[14:0];

endmodule // addr_former

`default_nettype wire

//--- rtl/core_special_registers.v
// Overview of operation
// - Low pc byte read/write, resets zero
// - Timeout flag set: power-up, watchdog clear, sleep
// - Timeout flag zero means watchdog expired
// - Powerdown set by watchdog clear; sleep clears
// - Power reset sets timeout/powerdown; others per cause
// - Power reset clears arithmetic flags; others keep
// - Zero flag follows result; software writable
// - Digit carry from bit three on add/sub
// - Carry from top bit on add/sub
// - Subtract adds two's complement; borrow inverted
// - Rotate loads carry with shifted-out bit
// - Pointer zero sixteen bits, resets zero
// - Pointer one sixteen bits, resets zero
// - Pointers accessed as separate high/low bytes
// - Bank select six bits, top address bits
// - Memory reachable direct or through pointers
// - Seven-bit pc upper latch, resets zero
// - Computed call loads pc from accumulator, latch
// - Pointer top bit selects program memory
`timescale 1ns/10ps
`default_nettype none

module core_special_registers (
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Reset cause: high for power-on or brown-out
    input wire power_reset,
    // Cause-driven flag values for other resets
    input wire cause_timeout,
    input wire cause_powerdown,
    // Register access from the execution core
    input wire [6:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Instruction events
    input wire watchdog_clear_instr,
    input wire sleep_instr,
    input wire watchdog_timeout,
    input wire computed_call_instr,
    input wire pc_advance,
    input wire [14:0] pc_next_seq,
    // Flag update from the execution unit
    input wire [2:0] flag_op,
    input wire [7:0] flag_opnd_a,
    input wire [7:0] flag_opnd_b,
    output reg [7:0] flag_result,
    // Direct addressing inputs
    input wire [6:0] file_offset,
    // Register state
    output reg [7:0] pc_low_byte,
    output reg [6:0] pc_high_byte,
    output reg [7:0] working_accumulator,
    output reg [15:0] indirect_pointer_zero,
    output reg [15:0] indirect_pointer_one,
    output reg timeout_flag,
    output reg powerdown_flag,
    // Formed addresses
    output reg [12:0] direct_addr,
    output reg [14:0] window_zero_addr,
    output reg window_zero_prog,
    output reg [14:0] window_one_addr,
    output reg window_one_prog
);
`include "core_sfr_defs.vh"

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    reg zero_reg;
    reg digit_carry_reg;
    reg carry_reg;
    reg [5:0] bank_reg;
    reg [6:0] latch_reg;
    reg [7:0] rdata_next;

    wire [7:0] alu_result;
    wire alu_zero;
    wire alu_dc;
    wire alu_carry;
    wire alu_carry_valid;
    wire [12:0] dir_addr_w;
    wire [14:0] ind0_addr_w;
    wire ind0_prog_w;
    wire [14:0] ind1_addr_w;
    wire ind1_prog_w;

    // Write strobe decode shared by every register
    function wr_hit;
        input wr;
        input [6:0] addr;
        input [6:0] target;
        begin
            wr_hit = wr && (addr == target);
        end
    endfunction

    wire wr_pcl = wr_hit(reg_wr, reg_addr, `OFF_PC_LOW_BYTE);
    wire wr_stat = wr_hit(reg_wr, reg_addr, `OFF_STATUS_FLAGS);
    wire wr_p0l = wr_hit(reg_wr, reg_addr, `OFF_PTR_ZERO_LOW);
    wire wr_p0h = wr_hit(reg_wr, reg_addr, `OFF_PTR_ZERO_HIGH);
    wire wr_p1l = wr_hit(reg_wr, reg_addr, `OFF_PTR_ONE_LOW);
    wire wr_p1h = wr_hit(reg_wr, reg_addr, `OFF_PTR_ONE_HIGH);
    wire wr_bsr = wr_hit(reg_wr, reg_addr, `OFF_BANK_SELECT);
    wire wr_acc = wr_hit(reg_wr, reg_addr, `OFF_WORKING_ACC);
    wire wr_lat = wr_hit(reg_wr, reg_addr, `OFF_PC_UPPER_LATCH);

    // ---------------------------------------------------------------
    // Sub-blocks
    // ---------------------------------------------------------------
    flag_alu u_flag_alu (
        .op(flag_op),
        .opnd_a(flag_opnd_a),
        .opnd_b(flag_opnd_b),
        .carry_in(carry_reg),
        .result(alu_result),
        .zero_out(alu_zero),
        .digit_carry_out(alu_dc),
        .carry_out(alu_carry),
        .carry_valid(alu_carry_valid)
    );

    addr_former u_addr_zero (
        .bank(bank_reg),
        .file_offset(file_offset),
        .pointer(indirect_pointer_zero),
        .direct_addr(dir_addr_w),
        .indirect_addr(ind0_addr_w),
        .indirect_is_prog(ind0_prog_w)
    );

    addr_former u_addr_one (
        .bank(bank_reg),
        .file_offset(file_offset),
        .pointer(indirect_pointer_one),
        .direct_addr(),
        .indirect_addr(ind1_addr_w),
        .indirect_is_prog(ind1_prog_w)
    );

    // ---------------------------------------------------------------
    // Program counter and upper latch
    // ---------------------------------------------------------------
    // Computed call wins over a register write; a write to the low
    // byte also pulls the upper bits from the latch as a jump does
    always @(posedge ref_clk) begin
        if (!resetn) begin
            pc_low_byte <= `RST_BYTE;
            pc_high_byte <= `RST_LATCH;
        end else if (computed_call_instr) begin
            pc_low_byte <= working_accumulator;
            pc_high_byte <= latch_reg;
        end else if (wr_pcl) begin
            pc_low_byte <= reg_wdata;
            pc_high_byte <= latch_reg;
        end else if (pc_advance) begin
            pc_low_byte <= pc_next_seq[7:0];
            pc_high_byte <= pc_next_seq[14:8];
        end
    end

    // Only seven bits stored; bit 7 is dropped on write
    always @(posedge ref_clk) begin
        if (!resetn) begin
            latch_reg <= `RST_LATCH;
        end else if (wr_lat) begin
            latch_reg <= reg_wdata[6:0];
        end
    end

    // ---------------------------------------------------------------
    // Working accumulator and bank select
    // ---------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            working_accumulator <= `RST_BYTE;
            bank_reg <= `RST_BANK;
        end else begin
            if (wr_acc) begin
                working_accumulator <= reg_wdata;
            end
            if (wr_bsr) begin
                bank_reg <= reg_wdata[5:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Indirect pointers, byte at a time
    // ---------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            indirect_pointer_zero <= `RST_POINTER;
            indirect_pointer_one <= `RST_POINTER;
        end else begin
            if (wr_p0l) begin
                indirect_pointer_zero[7:0] <= reg_wdata;
            end
            if (wr_p0h) begin
                indirect_pointer_zero[15:8] <= reg_wdata;
            end
            if (wr_p1l) begin
                indirect_pointer_one[7:0] <= reg_wdata;
            end
            if (wr_p1h) begin
                indirect_pointer_one[15:8] <= reg_wdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // Timeout and powerdown flags
    // ---------------------------------------------------------------
    // Read-only to software; instruction events set or clear them.
    // A timeout in the same cycle as a watchdog clear loses, since
    // the clear restarts the watchdog.
    always @(posedge ref_clk) begin
        if (!resetn) begin
            if (power_reset) begin
                timeout_flag <= 1'b1;
                powerdown_flag <= 1'b1;
            end else begin
                timeout_flag <= cause_timeout;
                powerdown_flag <= cause_powerdown;
            end
        end else begin
            if (watchdog_clear_instr || sleep_instr) begin
                timeout_flag <= 1'b1;
            end else if (watchdog_timeout) begin
                timeout_flag <= 1'b0;
            end
            if (sleep_instr) begin
                powerdown_flag <= 1'b0;
            end else if (watchdog_clear_instr) begin
                powerdown_flag <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Arithmetic flags
    // ---------------------------------------------------------------
    // Hardware update beats a software write in the same cycle
    always @(posedge ref_clk) begin
        if (!resetn) begin
            if (power_reset) begin
                zero_reg <= 1'b0;
                digit_carry_reg <= 1'b0;
                carry_reg <= 1'b0;
            end
        end else if (flag_op != `FOP_NONE) begin
            zero_reg <= alu_zero;
            if (flag_op == `FOP_ADD || flag_op == `FOP_SUB) begin
                digit_carry_reg <= alu_dc;
            end
            if (alu_carry_valid) begin
                carry_reg <= alu_carry;
            end
        end else if (wr_stat) begin
            zero_reg <= reg_wdata[`BIT_ZERO];
            digit_carry_reg <= reg_wdata[`BIT_DIGIT_CARRY];
            carry_reg <= reg_wdata[`BIT_CARRY];
        end
    end

    // ---------------------------------------------------------------
    // Registered result and addresses
    // ---------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            flag_result <= `RST_BYTE;
            direct_addr <= 13'h0000;
            window_zero_addr <= 15'h0000;
            window_zero_prog <= 1'b0;
            window_one_addr <= 15'h0000;
            window_one_prog <= 1'b0;
        end else begin
            flag_result <= alu_result;
            direct_addr <= dir_addr_w;
            window_zero_addr <= ind0_addr_w;
            window_zero_prog <= ind0_prog_w;
            window_one_addr <= ind1_addr_w;
            window_one_prog <= ind1_prog_w;
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    // Windows read zero here; the data path resolves them elsewhere.
    // Unmapped offsets also read zero so a stray access is harmless.
    always @* begin
        case (reg_addr)
            `OFF_PC_LOW_BYTE: begin
                rdata_next = pc_low_byte;
            end
            `OFF_STATUS_FLAGS: begin
                rdata_next = {3'h0, timeout_flag, powerdown_flag,
                    zero_reg, digit_carry_reg, carry_reg};
            end
            `OFF_PTR_ZERO_LOW: begin
                rdata_next = indirect_pointer_zero[7:0];
            end
            `OFF_PTR_ZERO_HIGH: begin
                rdata_next = indirect_pointer_zero[15:8];
            end
            `OFF_PTR_ONE_LOW: begin
                rdata_next = indirect_pointer_one[7:0];
            end
            `OFF_PTR_ONE_HIGH: begin
                rdata_next = indirect_pointer_one[15:8];
            end
            `OFF_BANK_SELECT: begin
                rdata_next = {2'h0, bank_reg};
            end
            `OFF_WORKING_ACC: begin
                rdata_next = working_accumulator;
            end
            `OFF_PC_UPPER_LATCH: begin
                rdata_next = {1'h0, latch_reg};
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Read data register
    // ---------------------------------------------------------------
    // Read data leaves through a flop, so it trails the address by one
    // clock; the core must hold the address across that edge
    always @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata <= `RST_BYTE;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

endmodule // core_special_registers

`default_nettype wire

//--- sim/exec_core_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_sfr_defs.vh"

// ---------------------------------------------------------------
// Execution core stand-in
// ---------------------------------------------------------------
module exec_core_model (
    // Clock
    input wire logic ref_clk,
    // Flag operation request
    output var logic [2:0] flag_op,
    output var logic [7:0] flag_opnd_a,
    output var logic [7:0] flag_opnd_b
);
    // Idle at time zero
    initial begin
        flag_op = `FOP_NONE;
        flag_opnd_a = 8'h00;
        flag_opnd_b = 8'h00;
    end

    // One operation held for one sampling edge, then operands inverted
    // so that a late sample never sees the old values by luck
    task automatic run_op(input [2:0] op, input [7:0] a, input [7:0] b);
        flag_op = op;
        flag_opnd_a = a;
        flag_opnd_b = b;
        @(posedge ref_clk);
        #1;
        flag_op = `FOP_NONE;
        flag_opnd_a = ~a;
        flag_opnd_b = ~b;
    endtask
endmodule // exec_core_model
`default_nettype wire

//--- sim/core_sfr_monitor.sv
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module core_sfr_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic power_reset,
    input wire logic cause_timeout,
    input wire logic cause_powerdown,
    // Register access
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    // Events
    input wire logic watchdog_clear_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    input wire logic computed_call_instr,
    // State
    input wire logic [7:0] working_accumulator,
    input wire logic [7:0] pc_low_byte,
    input wire logic [15:0] indirect_pointer_zero,
    input wire logic [15:0] indirect_pointer_one,
    input wire logic timeout_flag,
    input wire logic powerdown_flag,
    input wire logic window_zero_prog
);
    default clocking cb @(posedge ref_clk); endclocking

    // Reset checks run while reset is low, so no disable there
    AST_PTR_RESET: assert property (
        !resetn |=> indirect_pointer_zero == 16'h0000
            && indirect_pointer_one == 16'h0000 && pc_low_byte == 8'h00)
        else $error("pointers or pc low byte not cleared by reset");
    AST_POWER_FLAGS: assert property (
        !resetn && power_reset |=> timeout_flag && powerdown_flag)
        else $error("power reset did not set timeout and powerdown");
    AST_CAUSE_FLAGS: assert property (
        !resetn && !power_reset |=> timeout_flag == $past(cause_timeout)
            && powerdown_flag == $past(cause_powerdown))
        else $error("other reset did not load flags from cause");
    AST_SLEEP: assert property (disable iff (!resetn)
        sleep_instr |=> timeout_flag && !powerdown_flag)
        else $error("sleep did not set timeout and clear powerdown");
    AST_WDT_CLEAR: assert property (disable iff (!resetn)
        watchdog_clear_instr && !sleep_instr
            |=> timeout_flag && powerdown_flag)
        else $error("watchdog clear did not set both flags");
    AST_WDT_TIMEOUT: assert property (disable iff (!resetn)
        watchdog_timeout && !watchdog_clear_instr && !sleep_instr
            |=> !timeout_flag)
        else $error("watchdog expiry did not clear timeout flag");
    AST_CALL_LOAD: assert property (disable iff (!resetn)
        computed_call_instr |=> pc_low_byte == $past(working_accumulator))
        else $error("computed call did not load pc low byte");
    AST_PTR0_LOW_WR: assert property (disable iff (!resetn)
        reg_wr && reg_addr == 7'h04
            |=> indirect_pointer_zero[7:0] == $past(reg_wdata))
        else $error("pointer zero low byte write lost");
    AST_PTR1_HIGH_WR: assert property (disable iff (!resetn)
        reg_wr && reg_addr == 7'h07
            |=> indirect_pointer_one[15:8] == $past(reg_wdata))
        else $error("pointer one high byte write lost");
    AST_WIN_PROG: assert property (disable iff (!resetn)
        $past(resetn)
            |-> window_zero_prog == $past(indirect_pointer_zero[15]))
        else $error("window zero space select not from pointer top bit");
endmodule // core_sfr_monitor

bind core_special_registers core_sfr_monitor i_core_sfr_monitor (.*);
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_sfr_defs.vh"

// ---------------------------------------------------------------
// Top level bench
// ---------------------------------------------------------------
module testbench;
    logic ref_clk = 1'b0, resetn = 1'b0, power_reset = 1'b1;
    logic cause_timeout = 1'b0, cause_powerdown = 1'b0, reg_wr = 1'b0;
    logic [6:0] reg_addr = 7'h00, file_offset = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic watchdog_clear_instr = 1'b0, sleep_instr = 1'b0;
    logic watchdog_timeout = 1'b0, computed_call_instr = 1'b0;
    logic pc_advance = 1'b0;
    logic [14:0] pc_next_seq = 15'h0000;
    wire [2:0] flag_op;
    wire [7:0] flag_opnd_a, flag_opnd_b, flag_result, reg_rdata;
    wire [7:0] pc_low_byte, working_accumulator;
    wire [6:0] pc_high_byte;
    wire [15:0] indirect_pointer_zero, indirect_pointer_one;
    wire timeout_flag, powerdown_flag, window_zero_prog, window_one_prog;
    wire [12:0] direct_addr;
    wire [14:0] window_zero_addr, window_one_addr;
    int miscompares = 0, num_checks = 0;
    // Readback after 0xff everywhere: masks unimplemented bits
    logic [7:0] ff_exp [1:11] = '{8'h00, 8'hff, 8'h1f, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h3f, 8'hff, 8'h7f, 8'h00};

    always #50 ref_clk = ~ref_clk;

    core_special_registers i_core_special_registers (.*);
    exec_core_model i_exec_core_model (.*);

    // Bus and compare helpers; inputs move 1 ns after the edge
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input [15:0] exp, input [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic wr(input [6:0] a, input [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick;
        reg_wr = 1'b0;
        reg_wdata = ~d;
        tick; // Idle edge so the next strobe is not rewritten at once
    endtask
    task automatic rd(input [6:0] a, input [7:0] exp);
        reg_addr = a;
        tick; // Read data is registered: one edge behind the address
        chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    endtask
    task automatic pulse(input [4:0] e);
        {watchdog_clear_instr, sleep_instr, watchdog_timeout,
            computed_call_instr, pc_advance} = e;
        tick;
        {watchdog_clear_instr, sleep_instr, watchdog_timeout,
            computed_call_instr, pc_advance} = 5'h00;
        tick;
    endtask
    task automatic rst(input p, input ct, input cp, input int n);
        power_reset = p;
        cause_timeout = ct;
        cause_powerdown = cp;
        resetn = 1'b0;
        repeat (n) tick;
        resetn = 1'b1;
    endtask
    task automatic alu(input [2:0] op, input [7:0] a, input [7:0] b,
                       input [7:0] res, input [7:0] st);
        i_exec_core_model.run_op(op, a, b);
        chk("flag_result", {8'h00, res}, {8'h00, flag_result});
        rd(7'h03, st);
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        complete_run;
    end

    // Main sequence
    initial begin
        // Reset low from time zero: the first edge plus 15 more
        tick;
        rst(1'b1, 1'b0, 1'b0, 15);
        for (int a = 1; a < 12; a++)
            rd(a[6:0], a == 3 ? 8'h18 : 8'h00);
        for (int a = 1; a < 12; a++) wr(a[6:0], 8'hff);
        for (int a = 1; a < 12; a++) rd(a[6:0], ff_exp[a]);
        for (int a = 1; a < 12; a++) wr(a[6:0], 8'h00);
        rd(7'h03, 8'h18);
        alu(`FOP_ADD, 8'h0f, 8'h01, 8'h10, 8'h1a);
        alu(`FOP_ADD, 8'hff, 8'h01, 8'h00, 8'h1f);
        alu(`FOP_SUB, 8'h05, 8'h05, 8'h00, 8'h1f);
        alu(`FOP_LOGIC, 8'h3c, 8'h00, 8'h3c, 8'h1b);
        alu(`FOP_SUB, 8'h00, 8'h01, 8'hff, 8'h18);
        alu(`FOP_ROT_LEFT, 8'h81, 8'h00, 8'h02, 8'h19);
        alu(`FOP_ROT_RIGHT, 8'h02, 8'h00, 8'h81, 8'h18);
        // Flag events: sleep, watchdog expiry, watchdog clear
        pulse(5'b01000);
        rd(7'h03, 8'h10);
        pulse(5'b00100);
        rd(7'h03, 8'h00);
        pulse(5'b10000);
        rd(7'h03, 8'h18);
        // Computed call and sequential advance
        wr(7'h09, 8'h5a);
        chk("acc", 16'h005a, {8'h00, working_accumulator});
        wr(7'h0a, 8'h23);
        pulse(5'b00010);
        chk("pc_low_byte", 16'h005a, {8'h00, pc_low_byte});
        chk("pc_high_byte", 16'h0023, {9'h000, pc_high_byte});
        pc_next_seq = 15'h1234;
        pulse(5'b00001);
        rd(7'h02, 8'h34);
        wr(7'h02, 8'h77);
        rd(7'h02, 8'h77);
        chk("pc_high_byte", 16'h0023, {9'h000, pc_high_byte});
        // Pointer bytes and formed addresses
        wr(7'h05, 8'h81);
        wr(7'h04, 8'h34);
        wr(7'h07, 8'h12);
        wr(7'h06, 8'hab);
        wr(7'h08, 8'h3f);
        file_offset = 7'h55;
        tick;
        tick;
        chk("ptr0", 16'h8134, indirect_pointer_zero);
        chk("ptr1", 16'h12ab, indirect_pointer_one);
        chk("win0_addr", 16'h0134, {1'b0, window_zero_addr});
        chk("win0_prog", 16'h0001, {15'h0000, window_zero_prog});
        chk("win1_addr", 16'h12ab, {1'b0, window_one_addr});
        chk("win1_prog", 16'h0000, {15'h0000, window_one_prog});
        chk("direct_addr", 16'h1fd5, {3'h0, direct_addr});
        // Other reset keeps arithmetic flags, loads cause values
        wr(7'h03, 8'h07);
        rst(1'b0, 1'b0, 1'b1, 2);
        rd(7'h03, 8'h0f);
        rd(7'h04, 8'h00);
        rst(1'b1, 1'b0, 1'b0, 2);
        rd(7'h03, 8'h18);
        complete_run;
    end
endmodule // testbench
`default_nettype wire
